/* hdl/sce_tx.sv */
`timescale 1ns/10ps
`default_nettype none

module sce_tx #(
  parameter int LFSR_W = sce_pkg::LFSR_W
) (
  input  wire logic              I_MCLK,
  input  wire logic              I_RESET,
  input  wire logic              I_FRAME_START,
  input  wire logic              I_VALID,
  input  wire sce_pkg::sce_char_s I_CHAR,
  output logic                   O_READY,
  input  wire logic              I_READY,
  output logic                   O_VALID,
  output sce_pkg::sce_code_s     O_CODE,
  output logic                   O_CTRL_ERR,
  output logic                   O_LINE_ERR,
  output logic      [LFSR_W-1:0] O_LFSR
);

  // Number of ones in a word of up to ten bits.
  function automatic logic [3:0] f_ones(input logic [9:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 10; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction

  // Six-bit form for negative running disparity, abcdei.
  function automatic logic [5:0] f_enc6(
    input logic [4:0] lo,
    input logic       k
  );
    logic [5:0] c;
    case (lo)
      5'h00: c = 6'b100111;
      5'h01: c = 6'b011101;
      5'h02: c = 6'b101101;
      5'h03: c = 6'b110001;
      5'h04: c = 6'b110101;
      5'h05: c = 6'b101001;
      5'h06: c = 6'b011001;
      5'h07: c = 6'b111000;
      5'h08: c = 6'b111001;
      5'h09: c = 6'b100101;
      5'h0a: c = 6'b010101;
      5'h0b: c = 6'b110100;
      5'h0c: c = 6'b001101;
      5'h0d: c = 6'b101100;
      5'h0e: c = 6'b011100;
      5'h0f: c = 6'b010111;
      5'h10: c = 6'b011011;
      5'h11: c = 6'b100011;
      5'h12: c = 6'b010011;
      5'h13: c = 6'b110010;
      5'h14: c = 6'b001011;
      5'h15: c = 6'b101010;
      5'h16: c = 6'b011010;
      5'h17: c = 6'b111010;
      5'h18: c = 6'b110011;
      5'h19: c = 6'b100110;
      5'h1a: c = 6'b010110;
      5'h1b: c = 6'b110110;
      5'h1c: c = k ? 6'b001111 : 6'b001110;
      5'h1d: c = 6'b101110;
      5'h1e: c = 6'b011110;
      5'h1f: c = 6'b101011;
      default: c = 6'b100111;
    endcase
    return c;
  endfunction

  // Four-bit form for negative six-bit disparity, fghj.
  function automatic logic [3:0] f_enc4(
    input logic [2:0] hi,
    input logic       k
  );
    logic [3:0] c;
    case (hi)
      3'h0: c = 4'b1011;
      3'h1: c = k ? 4'b0110 : 4'b1001;
      3'h2: c = k ? 4'b1010 : 4'b0101;
      3'h3: c = 4'b1100;
      3'h4: c = 4'b1101;
      3'h5: c = k ? 4'b0101 : 4'b1010;
      3'h6: c = k ? 4'b1001 : 4'b0110;
      3'h7: c = k ? 4'b0111 : 4'b1110;
      default: c = 4'b1011;
    endcase
    return c;
  endfunction

  // True for the twelve control characters.
  function automatic logic f_ctrl_ok(
    input logic [4:0] lo,
    input logic [2:0] hi
  );
    return (lo == sce_pkg::LO_K28)
        || ((hi == sce_pkg::HI_X7)
            && ((lo == sce_pkg::LO_K23) || (lo == sce_pkg::LO_K27)
             || (lo == sce_pkg::LO_K29) || (lo == sce_pkg::LO_K30)));
  endfunction

  logic                        valid_reg;
  logic                        valid_next;
  sce_pkg::sce_code_s          code_reg;
  sce_pkg::sce_code_s          code_next;
  logic                        rd_reg;
  logic                        rd_next;
  logic                        ctrl_err_reg;
  logic                        ctrl_err_next;
  logic                        line_err_reg;
  logic                        line_err_next;
  logic                        last_bit_reg;
  logic                        last_bit_next;
  logic [3:0]                  run_reg;
  logic [3:0]                  run_next;
  logic                        accept;
  logic                        step;
  logic [sce_pkg::BYTE_W-1:0]  scr_data;
  logic [sce_pkg::BYTE_W-1:0]  enc_data;
  logic [sce_pkg::LO_W-1:0]    lo;
  logic [sce_pkg::HI_W-1:0]    hi;
  logic                        k;
  logic [5:0]                  six;
  logic [3:0]                  four;
  logic                        d6;
  logic                        six_unbal;
  logic                        four_unbal;
  logic                        alt_n;
  logic                        alt_p;
  logic [9:0]                  word;
  logic [3:0]                  ones;
  logic [3:0]                  run;
  logic [3:0]                  run_peak;
  logic                        bit_prev;

  // One-stage output register; it refills in the cycle it drains.
  assign O_READY = I_READY | ~valid_reg;
  assign accept  = I_VALID & O_READY;
  assign step    = accept & ~I_CHAR.ctrl;

  sce_scram #(
    .W(LFSR_W),
    .N(sce_pkg::BYTE_W)
  ) u_scram (
    .i_clk   (I_MCLK),
    .i_rst   (I_RESET),
    .i_reseed(I_FRAME_START),
    .i_step  (step),
    .i_data  (I_CHAR.data),
    .o_data  (scr_data),
    .o_state (O_LFSR)
  );

  // Control characters pass unscrambled.
  assign enc_data = I_CHAR.ctrl ? I_CHAR.data : scr_data;
  assign k        = I_CHAR.ctrl;
  assign lo       = enc_data[sce_pkg::LO_POS +: sce_pkg::LO_W];
  assign hi       = enc_data[sce_pkg::HI_POS +: sce_pkg::HI_W];

  // Six-bit step.
  always_comb begin
    six       = f_enc6(lo, k);
    six_unbal = f_ones({4'h0, six}) != sce_pkg::SIX_BAL;
    if (rd_reg && (six_unbal || (lo == sce_pkg::LO_D07 && !k))) begin
      six = ~six;
    end
    d6 = six_unbal ? ~rd_reg : rd_reg;
  end

  // Four-bit step fed by the six-bit disparity.
  always_comb begin
    alt_n = (hi == sce_pkg::HI_X7) && !k && !d6
         && ((lo == sce_pkg::LO_ALT_N0) || (lo == sce_pkg::LO_ALT_N1)
          || (lo == sce_pkg::LO_ALT_N2));
    alt_p = (hi == sce_pkg::HI_X7) && !k && d6
         && ((lo == sce_pkg::LO_ALT_P0) || (lo == sce_pkg::LO_ALT_P1)
          || (lo == sce_pkg::LO_ALT_P2));
    four       = f_enc4(hi, k);
    four_unbal = f_ones({6'h00, four}) != sce_pkg::FOUR_BAL;
    if (alt_n) begin
      four = sce_pkg::ALT_NEG;
    end else if (alt_p) begin
      four = sce_pkg::ALT_POS;
    end else if (d6 && (four_unbal || hi == sce_pkg::HI_X3 || k)) begin
      four = ~four;
    end
  end

  // Whole character and the new running disparity.
  always_comb begin
    word    = {six, four};
    rd_next = rd_reg;
    if (accept) begin
      rd_next = four_unbal ? ~d6 : d6;
    end
  end

  // Balance and run-length check on each produced character.
  always_comb begin
    ones     = f_ones(word);
    run      = run_reg;
    bit_prev = last_bit_reg;
    run_peak = 4'h0;
    for (int i = sce_pkg::CODE_W - 1; i >= 0; i--) begin
      if (word[i] == bit_prev) begin
        run = run + 4'h1;
      end else begin
        run = 4'h1;
      end
      bit_prev = word[i];
      if (run > run_peak) begin
        run_peak = run;
      end
    end
  end

  always_comb begin
    valid_next    = valid_reg & ~I_READY;
    code_next     = code_reg;
    ctrl_err_next = ctrl_err_reg;
    line_err_next = line_err_reg;
    last_bit_next = last_bit_reg;
    run_next      = run_reg;
    if (accept) begin
      valid_next     = 1'b1;
      code_next.code = word;
      code_next.rd   = rd_next;
      ctrl_err_next  = k & ~f_ctrl_ok(lo, hi);
      line_err_next  = (run_peak > sce_pkg::RUN_MAX)
                    || (ones < sce_pkg::ONES_MIN)
                    || (ones > sce_pkg::ONES_MAX);
      last_bit_next  = bit_prev;
      run_next       = run;
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      rd_reg <= sce_pkg::RD_RESET;
    end else begin
      rd_reg <= rd_next;
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      valid_reg     <= 1'b0;
      code_reg.code <= sce_pkg::CODE_RESET;
      code_reg.rd   <= sce_pkg::RD_RESET;
    end else begin
      valid_reg <= valid_next;
      code_reg  <= code_next;
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      ctrl_err_reg <= 1'b0;
      line_err_reg <= 1'b0;
      last_bit_reg <= 1'b0;
      run_reg      <= 4'h0;
    end else begin
      ctrl_err_reg <= ctrl_err_next;
      line_err_reg <= line_err_next;
      last_bit_reg <= last_bit_next;
      run_reg      <= run_next;
    end
  end

  assign O_VALID    = valid_reg;
  assign O_CODE     = code_reg;
  assign O_CTRL_ERR = ctrl_err_reg;
  assign O_LINE_ERR = line_err_reg;

endmodule

`default_nettype wire

/* include/sce_pkg.sv */
package sce_pkg;

  // Scrambler generator shape and seed.
  localparam int          LFSR_W    = 16;
  localparam logic [15:0] LFSR_SEED = 16'hffff;
  localparam logic [15:0] LFSR_TAPS = 16'h0039;

  // Character field widths and positions.
  localparam int BYTE_W = 8;
  localparam int CODE_W = 10;
  localparam int LO_W   = 5;
  localparam int HI_W   = 3;
  localparam int LO_POS = 0;
  localparam int HI_POS = 5;
  localparam int SIX_W  = 6;
  localparam int FOUR_W = 4;

  // Special field values of the code tables.
  localparam logic [4:0] LO_D07    = 5'h07;
  localparam logic [4:0] LO_K28    = 5'h1c;
  localparam logic [4:0] LO_K23    = 5'h17;
  localparam logic [4:0] LO_K27    = 5'h1b;
  localparam logic [4:0] LO_K29    = 5'h1d;
  localparam logic [4:0] LO_K30    = 5'h1e;
  localparam logic [4:0] LO_ALT_N0 = 5'h11;
  localparam logic [4:0] LO_ALT_N1 = 5'h12;
  localparam logic [4:0] LO_ALT_N2 = 5'h14;
  localparam logic [4:0] LO_ALT_P0 = 5'h0b;
  localparam logic [4:0] LO_ALT_P1 = 5'h0d;
  localparam logic [4:0] LO_ALT_P2 = 5'h0e;
  localparam logic [2:0] HI_X3     = 3'h3;
  localparam logic [2:0] HI_X7     = 3'h7;
  localparam logic [3:0] ALT_NEG   = 4'h7;
  localparam logic [3:0] ALT_POS   = 4'h8;

  // Balance and run-length limits.
  localparam logic [3:0] SIX_BAL  = 4'h3;
  localparam logic [3:0] FOUR_BAL = 4'h2;
  localparam logic [3:0] ONES_MIN = 4'h4;
  localparam logic [3:0] ONES_MAX = 4'h6;
  localparam logic [3:0] RUN_MAX  = 4'h5;

  // Reset values.
  localparam logic       RD_RESET   = 1'b0;
  localparam logic [9:0] CODE_RESET = 10'h000;

  typedef struct packed {
    logic       ctrl;
    logic [7:0] data;
  } sce_char_s;

  typedef struct packed {
    logic [9:0] code;
    logic       rd;
  } sce_code_s;

endpackage

/* hdl/sce_scram.sv */
`timescale 1ns/10ps
`default_nettype none

module sce_scram #(
  parameter int W = sce_pkg::LFSR_W,
  parameter int N = sce_pkg::BYTE_W
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_reseed,
  input  wire logic         i_step,
  input  wire logic [N-1:0] i_data,
  output logic      [N-1:0] o_data,
  output logic      [W-1:0] o_state
);

  logic [W-1:0] state_reg;
  logic [W-1:0] state_next;
  logic [W-1:0] cur;
  logic [W-1:0] s;

  // A frame start reseeds; a byte in the same cycle uses the seed.
  always_comb begin
    cur = i_reseed ? W'(sce_pkg::LFSR_SEED) : state_reg;
    s   = cur;
    for (int i = 0; i < N; i++) begin
      o_data[i] = i_data[i] ^ s[W-1];
      s = {s[W-2:0], 1'b0}
        ^ (s[W-1] ? W'(sce_pkg::LFSR_TAPS) : '0);
    end
    state_next = i_step ? s : cur;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= W'(sce_pkg::LFSR_SEED);
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_state = state_reg;

endmodule

`default_nettype wire

/* bench/sce_tx_props.sv */
`timescale 1ns/10ps
`default_nettype none

module sce_tx_props #(
  parameter int LFSR_W = 16
) (
  input wire logic               I_MCLK,
  input wire logic               I_RESET,
  input wire logic               I_FRAME_START,
  input wire logic               I_VALID,
  input wire sce_pkg::sce_char_s I_CHAR,
  input wire logic               O_READY,
  input wire logic               I_READY,
  input wire logic               O_VALID,
  input wire sce_pkg::sce_code_s O_CODE,
  input wire logic               O_CTRL_ERR,
  input wire logic               O_LINE_ERR,
  input wire logic [LFSR_W-1:0]  O_LFSR
);
  logic       tkd_reg;
  logic       rd_reg;
  logic [3:0] ones;

  function automatic logic [15:0] adv8(input logic [15:0] s);
    for (int i = 0; i < 8; i++) begin
      s = {s[14:0], 1'b0} ^ (s[15] ? 16'h0039 : 16'h0000);
    end
    return s;
  endfunction

  function automatic logic legal(input logic [7:0] d);
    return d[4:0] == 5'h1c ||
      (d[7:5] == 3'h7 && d[4:0] inside {5'h17, 5'h1b, 5'h1d, 5'h1e});
  endfunction

  assign ones = 4'($countones(O_CODE.code));

  // Running disparity before the character now on the output.
  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      tkd_reg <= 1'b0;
      rd_reg  <= 1'b0;
    end else begin
      tkd_reg <= I_VALID && O_READY;
      if (tkd_reg) begin
        rd_reg <= O_CODE.rd;
      end
    end
  end

  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RESET);

  sequence s_dtake; I_VALID && O_READY && !I_CHAR.ctrl; endsequence
  sequence s_ktake; I_VALID && O_READY && I_CHAR.ctrl; endsequence

  property p_answer; I_VALID && O_READY |=> O_VALID; endproperty
  property p_hold;
    O_VALID && !I_READY |-> !O_READY ##1 (O_VALID && $stable(O_CODE));
  endproperty
  property p_weight; O_VALID |-> ones inside {[4:6]}; endproperty
  property p_rd_bal; tkd_reg && ones == 4'h5 |-> O_CODE.rd == rd_reg;
  endproperty
  property p_rd_pick; tkd_reg && ones != 4'h5 |-> (ones == 4'h4) == rd_reg;
  endproperty
  property p_rd_set; O_VALID && ones != 4'h5 |-> O_CODE.rd == (ones > 4'h5);
  endproperty
  property p_seed;
    I_FRAME_START && !(I_VALID && O_READY && !I_CHAR.ctrl)
      |=> O_LFSR == sce_pkg::LFSR_SEED;
  endproperty
  property p_adv;
    s_dtake |=> O_LFSR == adv8($past(I_FRAME_START) ? 16'hffff : $past(O_LFSR));
  endproperty
  property p_keep;
    !I_FRAME_START && !(I_VALID && O_READY && !I_CHAR.ctrl) |=> $stable(O_LFSR);
  endproperty
  property p_k28;
    s_ktake ##0 (I_CHAR.data[4:0] == 5'h1c)
      |=> O_CODE.code[9:4] == (rd_reg ? 6'h30 : 6'h0f);
  endproperty
  property p_kerr; s_ktake |=> O_CTRL_ERR == !legal($past(I_CHAR.data));
  endproperty
  property p_line; O_VALID |-> !O_LINE_ERR; endproperty

  a_answer: assert property (p_answer) else $error("no output");
  a_hold: assert property (p_hold) else $error("output not held");
  a_weight: assert property (p_weight) else $error("bad weight");
  a_rd_bal: assert property (p_rd_bal) else $error("rd moved");
  a_rd_pick: assert property (p_rd_pick) else $error("bad pick");
  a_rd_set: assert property (p_rd_set) else $error("bad rd");
  a_seed: assert property (p_seed) else $error("no reseed");
  a_adv: assert property (p_adv) else $error("bad step");
  a_keep: assert property (p_keep) else $error("lfsr moved");
  a_k28: assert property (p_k28) else $error("bad k28");
  a_kerr: assert property (p_kerr) else $error("bad ctrl flag");
  a_line: assert property (p_line) else $error("line error");
endmodule

bind sce_tx sce_tx_props #(.LFSR_W(LFSR_W)) u_props (
  .I_MCLK(I_MCLK), .I_RESET(I_RESET), .I_FRAME_START(I_FRAME_START),
  .I_VALID(I_VALID), .I_CHAR(I_CHAR), .O_READY(O_READY),
  .I_READY(I_READY), .O_VALID(O_VALID), .O_CODE(O_CODE),
  .O_CTRL_ERR(O_CTRL_ERR), .O_LINE_ERR(O_LINE_ERR), .O_LFSR(O_LFSR)
);

`default_nettype wire

/* bench/sce_rx_model.sv */
`timescale 1ns/10ps
`default_nettype none

module sce_rx_model (
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  input  wire logic               i_stall,
  input  wire logic               i_valid,
  input  wire sce_pkg::sce_code_s i_code,
  output logic                    o_ready,
  output int                      o_errs,
  output int                      o_checks
);
  int         rd_m;
  int         run;
  int         ones;
  logic       last;
  logic [9:0] c;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_m = -1;
      run = 0;
      last = 1'b0;
      o_errs = 0;
      o_checks = 0;
      o_ready <= 1'b1;
    end else begin
      o_ready <= !i_stall;
      if (i_valid && o_ready) begin
        c = i_code.code;
        ones = $countones(c);
        rd_m = rd_m + 2 * ones - 10;
        o_checks++;
        if (ones < 4 || ones > 6 || (rd_m != 1 && rd_m != -1) ||
            (rd_m > 0) !== i_code.rd) begin
          $display("[FAIL] rx char expected legal got %h", c);
          o_errs++;
        end
        for (int b = 9; b >= 0; b--) begin
          run = (c[b] === last) ? run + 1 : 1;
          last = c[b];
          if (run > 5) begin
            $display("[FAIL] rx run expected 5 got %0d", run);
            o_errs++;
          end
        end
      end
    end
  end
endmodule

`default_nettype wire

/* bench/test_scrambler_8b10b_encoder.sv */
`timescale 1ns/10ps
`default_nettype none

module test_scrambler_8b10b_encoder;
  logic               I_MCLK;
  logic               I_RESET;
  logic               I_FRAME_START;
  logic               I_VALID;
  sce_pkg::sce_char_s I_CHAR;
  logic               O_READY;
  logic               I_READY;
  logic               O_VALID;
  sce_pkg::sce_code_s O_CODE;
  logic               O_CTRL_ERR;
  logic               O_LINE_ERR;
  logic [15:0]        O_LFSR;
  logic               stall;
  logic [15:0]        ks;
  int                 num_errors;
  int                 check_count;
  int                 m_errs;
  int                 m_checks;

  sce_tx dut (.I_MCLK(I_MCLK), .I_RESET(I_RESET),
    .I_FRAME_START(I_FRAME_START), .I_VALID(I_VALID), .I_CHAR(I_CHAR),
    .O_READY(O_READY), .I_READY(I_READY), .O_VALID(O_VALID),
    .O_CODE(O_CODE), .O_CTRL_ERR(O_CTRL_ERR), .O_LINE_ERR(O_LINE_ERR),
    .O_LFSR(O_LFSR));

  sce_rx_model rx (.i_clk(I_MCLK), .i_rst(I_RESET), .i_stall(stall),
    .i_valid(O_VALID), .i_code(O_CODE), .o_ready(I_READY),
    .o_errs(m_errs), .o_checks(m_checks));

  always #4 I_MCLK = ~I_MCLK;

  // Receiver-side generator giving the next keystream byte.
  function automatic logic [7:0] keyb();
    logic [7:0] k;
    for (int i = 0; i < 8; i++) begin
      k[i] = ks[15];
      ks = {ks[14:0], 1'b0} ^ (ks[15] ? 16'h0039 : 16'h0000);
    end
    return k;
  endfunction

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h got %h", nm, exp, got);
      num_errors++;
    end
  endtask

  // Sends one character, held until taken, and judges the answer.
  task automatic send(logic fs, logic k, logic [7:0] b, logic err,
                      logic [9:0] code, logic rd);
    logic [7:0] x;
    logic       acc;
    int         n;
    x = b;
    n = 0;
    if (fs) ks = 16'hffff;
    if (!k) x = b ^ keyb();
    I_FRAME_START = fs;
    I_CHAR = {k, x};
    I_VALID = 1'b1;
    do begin
      @(negedge I_MCLK);
      acc = O_READY;
      @(posedge I_MCLK);
      #1;
      n++;
    end while (!acc && n < 50);
    chk("taken", 1, acc);
    chk("valid", 1, O_VALID);
    chk("ctrl_err", err, O_CTRL_ERR);
    chk("line_err", 0, O_LINE_ERR);
    if (!err) chk("code", {code, rd}, O_CODE);
    chk("lfsr", ks, O_LFSR);
  endtask

  task automatic t_reset();
    chk("lfsr", 16'hffff, O_LFSR);
    chk("valid", 0, O_VALID);
    chk("ready", 1, O_READY);
    chk("ctrl_err", 0, O_CTRL_ERR);
    chk("line_err", 0, O_LINE_ERR);
  endtask

  task automatic t_table();
    send(1, 0, 8'hb5, 0, 10'h2aa, 0);
    send(0, 0, 8'hb5, 0, 10'h2aa, 0);
    send(0, 1, 8'hbc, 0, 10'h0fa, 1);
    send(0, 1, 8'hbc, 0, 10'h305, 0);
    send(0, 0, 8'hf1, 0, 10'h237, 1);
    send(1, 0, 8'heb, 0, 10'h348, 0);
    send(0, 0, 8'he7, 0, 10'h38e, 1);
    send(0, 0, 8'he7, 0, 10'h071, 0);
    send(0, 0, 8'he7, 0, 10'h38e, 1);
    send(1, 1, 8'hfc, 0, 10'h307, 1);
    send(0, 1, 8'hf7, 0, 10'h057, 1);
  endtask

  task automatic t_stall();
    I_VALID = 1'b0;
    I_FRAME_START = 1'b0;
    stall = 1'b1;
    @(posedge I_MCLK);
    #1;
    send(0, 0, 8'hb5, 0, 10'h2aa, 1);
    I_CHAR = {1'b0, 8'h00};
    repeat (3) @(posedge I_MCLK);
    #1;
    chk("ready", 0, O_READY);
    chk("held", {10'h2aa, 1'b1}, O_CODE);
    chk("lfsr", ks, O_LFSR);
    stall = 1'b0;
    send(0, 1, 8'hbc, 0, 10'h305, 0);
    send(0, 1, 8'h01, 1, 10'h000, 0);
  endtask

  task automatic tally_and_finish();
    num_errors = num_errors + m_errs;
    check_count = check_count + m_checks;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #(5000 * 8);
    num_errors++;
    tally_and_finish();
  end

  initial begin
    I_MCLK = 1'b0;
    I_RESET = 1'b1;
    I_FRAME_START = 1'b0;
    I_VALID = 1'b0;
    I_CHAR = '0;
    stall = 1'b0;
    ks = 16'hffff;
    num_errors = 0;
    check_count = 0;
    repeat (2) @(posedge I_MCLK);
    #1;
    I_RESET = 1'b0;
    t_reset();
    t_table();
    t_stall();
    @(posedge I_MCLK);
    #1;
    I_VALID = 1'b0;
    repeat (3) @(posedge I_MCLK);
    tally_and_finish();
  end
endmodule

`default_nettype wire
